// [logic/eesif_defines.vh]
// How it works
// - Writing one to a status flag position clears that flag; an event in the same clock keeps it set.
// - Writing zero to a flag position leaves the flag unchanged.
// - Bits 31 to 5 and bit 3 read zero; software writes zero.
// - Bit 4 sets when PAUSE retransmissions exceed the retry limit under flow control.
// - Bit 2 sets on every rising or falling change of the link input, except in the first three clocks after reset.
// - Bit 1 sets when a wake-up frame is detected.
// - Bit 0 sets when the PHY reports an illegal carrier; fast changes may be missed.
// - Enable bits 4, 2, 1, 0 gate the matching flags; all zero after reset.
// - The status events can be reported to the CPU as an interrupt request.
`ifndef EESIF_DEFINES_VH
`define EESIF_DEFINES_VH
`define EESIF_ADDR_STATUS    4'h0
`define EESIF_ADDR_ENABLE    4'h4
`define EESIF_ADDR_LIMIT     4'h8
`define EESIF_ADDR_CTRL      4'hc
`define EESIF_BIT_RETRY      4
`define EESIF_BIT_LINK       2
`define EESIF_BIT_WAKE       1
`define EESIF_BIT_CARRIER    0
`define EESIF_FLAG_MASK      32'h0000_0017
`define EESIF_RST_STATUS     32'h0000_0000
`define EESIF_RST_ENABLE     32'h0000_0000
`define EESIF_RST_LIMIT      8'h0f
`define EESIF_CTRL_FLOW      0
`endif

// [logic/eesif_sync.v]
`timescale 1ns/1ps
// ****************************************
// Two-stage synchroniser for pin inputs.
// ****************************************
module eesif_sync (
  input  wire mclk,
  input  wire nrst,
  input  wire din,
  output wire dout
);
  reg stage1;
  reg stage2;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
    end
  end

  assign dout = stage2;
endmodule

// [logic/eesif_retry.v]
`timescale 1ns/1ps
`include "eesif_defines.vh"
// ****************************************
// PAUSE retransmission counter.
// ****************************************
module eesif_retry (
  input  wire       mclk,
  input  wire       nrst,
  input  wire       flow_en,
  input  wire [7:0] pause_retry_limit,
  input  wire       pause_resend,
  input  wire       pause_done,
  output reg        overflow_pulse
);
  reg [7:0] count;
  reg       fired;

  // The count saturates so a stuck partner cannot wrap it back to zero.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count          <= 8'h00;
      fired          <= 1'b0;
      overflow_pulse <= 1'b0;
    end else begin
      overflow_pulse <= 1'b0;
      if (!flow_en || pause_done) begin
        count <= 8'h00;
        fired <= 1'b0;
      end else if (pause_resend) begin
        if (count != 8'hff) begin
          count <= count + 8'h01;
        end
        if (count >= pause_retry_limit && !fired) begin
          overflow_pulse <= 1'b1;
          fired          <= 1'b1;
        end
      end
    end
  end
endmodule

// [logic/eesif_top.v]
`timescale 1ns/1ps
`include "eesif_defines.vh"
// ****************************************
// Ethernet event status and interrupt enable.
// ****************************************
module eesif_top (
  input  wire        mclk,
  input  wire        nrst,
  input  wire [3:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  input  wire        phy_link_input,
  input  wire        phy_bad_carrier,
  input  wire        wake_frame_det,
  input  wire        pause_resend,
  input  wire        pause_done,
  output wire        mac_summary_irq_bit
);
  reg  [31:0] ether_event_status;
  reg  [31:0] ether_event_irq_enable;
  reg  [7:0]  pause_retry_limit;
  reg         flow_en;
  reg         link_prev;
  reg         carrier_prev;
  reg  [31:0] next_status;
  reg  [31:0] set_vec;
  wire        link_s;
  wire        carrier_s;
  wire        retry_over;
  wire        wr_status;

  // ****************************************
  // Input synchronisers and PAUSE retry counter.
  // ****************************************
  eesif_sync u_link_sync (
    .mclk (mclk),
    .nrst (nrst),
    .din  (phy_link_input),
    .dout (link_s)
  );

  eesif_sync u_carrier_sync (
    .mclk (mclk),
    .nrst (nrst),
    .din  (phy_bad_carrier),
    .dout (carrier_s)
  );

  eesif_retry u_retry (
    .mclk              (mclk),
    .nrst              (nrst),
    .flow_en           (flow_en),
    .pause_retry_limit (pause_retry_limit),
    .pause_resend      (pause_resend),
    .pause_done        (pause_done),
    .overflow_pulse    (retry_over)
  );

  // Link history is trusted only once the synchroniser holds the real pin level.
  // A pin that is already high at release would otherwise look like a change.
  reg  [1:0]  link_warm;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      link_prev    <= 1'b0;
      link_warm    <= 2'h0;
      carrier_prev <= 1'b0;
    end else begin
      link_prev    <= link_s;
      if (link_warm != 2'h3) begin
        link_warm <= link_warm + 2'h1;
      end
      carrier_prev <= carrier_s;
    end
  end

  // ****************************************
  // Event flags.
  // ****************************************
  assign wr_status = wr && (addr == `EESIF_ADDR_STATUS);

  always @* begin
    set_vec = 32'h0000_0000;
    set_vec[`EESIF_BIT_RETRY]   = retry_over && flow_en;
    set_vec[`EESIF_BIT_LINK]    = (link_warm == 2'h3) && (link_s != link_prev);
    set_vec[`EESIF_BIT_WAKE]    = wake_frame_det;
    set_vec[`EESIF_BIT_CARRIER] = carrier_s && !carrier_prev;
    next_status = ether_event_status;
    if (wr_status) begin
      next_status = ether_event_status & ~wdata;
    end
    next_status = (next_status | set_vec) & `EESIF_FLAG_MASK;
  end

  // ****************************************
  // Registers.
  // ****************************************
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ether_event_status     <= `EESIF_RST_STATUS;
      ether_event_irq_enable <= `EESIF_RST_ENABLE;
      pause_retry_limit      <= `EESIF_RST_LIMIT;
      flow_en                <= 1'b0;
    end else begin
      ether_event_status <= next_status;
      if (wr && addr == `EESIF_ADDR_ENABLE) begin
        ether_event_irq_enable <= wdata & `EESIF_FLAG_MASK;
      end
      if (wr && addr == `EESIF_ADDR_LIMIT) begin
        pause_retry_limit <= wdata[7:0];
      end
      if (wr && addr == `EESIF_ADDR_CTRL) begin
        flow_en <= wdata[`EESIF_CTRL_FLOW];
      end
    end
  end

  // Unmapped addresses read zero.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        `EESIF_ADDR_STATUS: rdata <= ether_event_status;
        `EESIF_ADDR_ENABLE: rdata <= ether_event_irq_enable;
        `EESIF_ADDR_LIMIT:  rdata <= {24'h00_0000, pause_retry_limit};
        `EESIF_ADDR_CTRL:   rdata <= {31'h0000_0000, flow_en};
        default:            rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  assign mac_summary_irq_bit = |(ether_event_status & ether_event_irq_enable);
endmodule

// [testbench/eesif_sva.sv]
`timescale 1ns/1ps
`include "eesif_defines.vh"
// ****
// Port checker.
// ****
module eesif_sva (
  input wire        mclk,
  input wire        nrst,
  input wire [3:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata,
  input wire        phy_link_input,
  input wire        phy_bad_carrier,
  input wire        wake_frame_det,
  input wire        pause_resend,
  input wire        pause_done,
  input wire        mac_summary_irq_bit
);
  // Shadow of the enable register, so irq checks know which flags count.
  reg  [31:0] en;
  wire        irq = mac_summary_irq_bit;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) en <= 32'h0000_0000;
    else if (wr && addr == `EESIF_ADDR_ENABLE) en <= wdata & `EESIF_FLAG_MASK;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0000_0000) else $error("rdata");
  rsv_zero_a: assert property ($past(rd) |-> rdata[31:5] == 0 && !rdata[3]) else $error("rsv");
  en_read_a: assert property ($past(rd && addr == 4'h4) |-> rdata == en) else $error("en");
  en_off_a: assert property (en == 0 |-> !irq) else $error("en off");
  irq_hold_a: assert property (irq && !wr |=> irq) else $error("hold");
  keep_zero_a: assert property (irq && wr && addr == 0 && wdata == 0 |=> irq) else $error("w0");
  wake_irq_a: assert property (wake_frame_det && en[1] && !wr |=> irq) else $error("wake");
  link_irq_a: assert property ($changed(phy_link_input) && en[2] |-> ##[1:6] irq) else $error("lnk");
  carr_irq_a: assert property ($rose(phy_bad_carrier) && en[0] |-> ##[1:6] irq) else $error("car");
  cover property (wake_frame_det && en[1]);
  cover property ($changed(phy_link_input) && en[2]);
  cover property (irq && wr && addr == 0 && wdata != 0);
endmodule

// [testbench/eesif_phy.sv]
`timescale 1ns/1ps
// ****
// PHY status pins.
// ****
module eesif_phy (
  input  wire mclk,
  input  wire flip,
  input  wire hit,
  output reg  link = 1'b0,
  output reg  carrier = 1'b0
);
  reg [2:0] cnt = 3'h0;
  // Carrier is held several cycles so the pin synchroniser cannot miss it.
  always @(posedge mclk) begin
    if (flip) link <= ~link;
    cnt <= hit ? 3'h4 : cnt - (cnt != 3'h0);
    carrier <= hit || cnt > 3'h1;
  end
endmodule

// [testbench/eesif_top_test.sv]
`timescale 1ns/1ps
// ****
// Bench.
// ****
module eesif_top_test;
  reg mclk, nrst, wr, rd, wake, res, done, flip, hit;
  reg [3:0] addr;
  reg [31:0] wdata, q;
  wire [31:0] rdata;
  wire irq, link, carr;
  integer miscompares, n_checks, i;
  eesif_phy phy (.mclk(mclk), .flip(flip), .hit(hit), .link(link), .carrier(carr));
  eesif_top uut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .phy_link_input(link), .phy_bad_carrier(carr), .wake_frame_det(wake),
    .pause_resend(res), .pause_done(done), .mac_summary_irq_bit(irq));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [31:0] d);
    begin
      @(posedge mclk); addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge mclk); wr <= 1'b0;
    end
  endtask
  task rd_chk(input [3:0] a, input [31:0] e);
    begin
      @(posedge mclk); addr <= a; rd <= 1'b1;
      @(posedge mclk); rd <= 1'b0;
      #1 chk(rdata, e);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task t_regs;
    begin
      rd_chk(4'h0, 32'h0000_0000);
      rd_chk(4'h4, 32'h0000_0000);
      rd_chk(4'h2, 32'h0000_0000);
      wr_reg(4'h4, 32'hffff_ffff);
      rd_chk(4'h4, 32'h0000_0017);
    end
  endtask
  task t_wake;
    begin
      @(posedge mclk); wake <= 1'b1;
      @(posedge mclk); wake <= 1'b0;
      rd_chk(4'h0, 32'h0000_0002);
      chk(irq, 1'b1);
      wr_reg(4'h0, 32'h0000_0000);
      rd_chk(4'h0, 32'h0000_0002);
      wr_reg(4'h4, 32'h0000_0015);
      #1 chk(irq, 1'b0);
      wr_reg(4'h0, 32'h0000_0002);
      rd_chk(4'h0, 32'h0000_0000);
      @(posedge mclk); wake <= 1'b1; addr <= 4'h0; wdata <= 32'h0000_0002; wr <= 1'b1;
      @(posedge mclk); wake <= 1'b0; wr <= 1'b0;
      rd_chk(4'h0, 32'h0000_0002);
      wr_reg(4'h0, 32'h0000_0002);
      rd_chk(4'h0, 32'h0000_0000);
    end
  endtask
  task t_pins;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        @(posedge mclk); flip <= i < 2; hit <= i == 2;
        @(posedge mclk); flip <= 1'b0; hit <= 1'b0;
        repeat (8) @(posedge mclk);
        rd_chk(4'h0, i < 2 ? 32'h0000_0004 : 32'h0000_0001);
        chk(irq, 1'b1);
        wr_reg(4'h0, 32'h0000_0017);
      end
    end
  endtask
  task t_retry;
    begin
      wr_reg(4'h8, 32'h0000_0002);
      repeat (4) begin
        @(posedge mclk); res <= 1'b1;
        @(posedge mclk); res <= 1'b0;
      end
      rd_chk(4'h0, 32'h0000_0000);
      wr_reg(4'hc, 32'h0000_0001);
      @(posedge mclk); done <= 1'b1;
      @(posedge mclk); done <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
        rd_chk(4'h0, 32'h0000_0000);
        @(posedge mclk); res <= 1'b1;
        @(posedge mclk); res <= 1'b0;
      end
      @(posedge mclk);
      rd_chk(4'h0, 32'h0000_0010);
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #100000 miscompares = miscompares + 1;
    stop_test;
  end
  initial begin
    {nrst, wr, rd, wake, res, done, flip, hit} = 8'h00;
    addr = 4'h0; wdata = 32'h0000_0000; miscompares = 0; n_checks = 0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    t_regs; t_wake; t_pins; t_retry;
    stop_test;
  end
endmodule
bind eesif_top eesif_sva chk_i (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .phy_link_input(phy_link_input), .phy_bad_carrier(phy_bad_carrier),
  .wake_frame_det(wake_frame_det), .pause_resend(pause_resend), .pause_done(pause_done),
  .mac_summary_irq_bit(mac_summary_irq_bit));
